// ==== shared/irq_ctrl_pkg.sv ====
package irq_ctrl_pkg;
    // register byte offsets on the bus
    localparam logic [4:0] OFS_MAIN = 5'h00;
    localparam logic [4:0] OFS_EDGES = 5'h04;
    localparam logic [4:0] OFS_EXT = 5'h08;
    localparam logic [4:0] OFS_RESET_CTL = 5'h0C;
    localparam logic [4:0] OFS_STATUS = 5'h10;
    // values after reset
    localparam logic [7:0] RST_MAIN = 8'h00;
    localparam logic [7:0] RST_EDGES = 8'hF5;
    localparam logic [7:0] RST_EXT = 8'hC0;
    // implemented bits, the rest read zero
    localparam logic [7:0] MASK_EDGES = 8'hF5;
    localparam logic [7:0] MASK_EXT = 8'hDB;
    // field positions in the main register
    localparam int B_HIGH_EN = 7;
    localparam int B_LOW_EN = 6;
    localparam int B_T0_EN = 5;
    localparam int B_E0_EN = 4;
    localparam int B_PC_EN = 3;
    localparam int B_T0_FLAG = 2;
    localparam int B_E0_FLAG = 1;
    localparam int B_PC_FLAG = 0;
    // field positions in the edge/priority register
    localparam int B_PULLUP_DIS = 7;
    localparam int B_E0_EDGE = 6;
    localparam int B_E1_EDGE = 5;
    localparam int B_E2_EDGE = 4;
    localparam int B_T0_PRIO = 2;
    localparam int B_PC_PRIO = 0;
    // field positions in the external pin register
    localparam int B_E2_PRIO = 7;
    localparam int B_E1_PRIO = 6;
    localparam int B_E2_EN = 4;
    localparam int B_E1_EN = 3;
    localparam int B_E2_FLAG = 1;
    localparam int B_E1_FLAG = 0;
    // priority mode bit in the reset control register
    localparam int B_PRIO_MODE = 7;
    // program counter width and vectors
    localparam int PC_W = 21;
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    // core clocks per instruction cycle
    localparam int CLKS_PER_INSTR = 4;
    localparam int PRIME_CYCLES = 3;
    // vectoring sequence states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PUSH = 2'b01,
        ST_LOAD = 2'b10
    } vec_state_type;
endpackage

// ==== core/two_level_priority_interrupt_ctrl.sv ====
`timescale 1ns/10ps
// Overview of operation
// - high vector 000008h, low vector 000018h
// - high pre-empts low, never the reverse
// - each source has flag, enable, priority; pin 0 always high
// - priority mode only while its bit set
// - bit7 gates high, bit6 gates low
// - flag, enable, global enable all set vectors
// - compatibility mode: one vector, bit6 peripherals
// - accepting clears the admitting global enable
// - push return address, load vector
// - return instruction sets that enable again
// - pin events vector within three-four cycles
// - flags set regardless of any enable
// - main bit7 disables all, enables high
// - main bit6 enables peripherals or low
// - main bits 5..0 enables and flags
// - port change flag follows pin mismatch
// - edge select bits, 1 rising, 0 falling
// - timer and port change priority bits
// - pull-up disable bit overrides port latches
// - ext pins 1, 2 priority, enable, flag
// - unimplemented positions always read zero
module two_level_priority_interrupt_ctrl
    import irq_ctrl_pkg::*;
#(
    parameter int PERIPH_N = 4
) (
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic timer0_overflow_in,
    input wire logic [2:0] ext_pin_in,
    input wire logic [3:0] upper_four_port_pins_in,
    input wire logic port_read_in,
    input wire logic [PERIPH_N-1:0] periph_req_in,
    input wire logic [PERIPH_N-1:0] periph_prio_in,
    input wire logic [7:0] port_latch_in,
    output logic [7:0] pullup_en_out,
    input wire logic [PC_W-1:0] return_addr_in,
    input wire logic return_from_irq_instr_in,
    output logic stack_push_out,
    output logic [PC_W-1:0] stack_data_out,
    output logic pc_load_out,
    output logic [PC_W-1:0] pc_vector_out
);
    // register state
    logic [7:0] interrupt_control_main;
    logic [7:0] interrupt_control_edges_priority;
    logic [7:0] interrupt_control_external_pins;
    logic priority_mode_on;
    logic [7:0] next_main;
    logic [7:0] next_ext;
    // bus wait state, one per access
    logic ack;
    // pin synchronisers and edge history
    logic [2:0] ext_s1;
    logic [2:0] ext_s2;
    logic [2:0] ext_d;
    logic [3:0] chg_s1;
    logic [3:0] chg_s2;
    logic [3:0] chg_ref;
    logic [1:0] prime_cnt;
    // instruction cycle divider
    logic [1:0] div_cnt;
    // vectoring sequence
    vec_state_type state;
    vec_state_type next_state;
    logic take_high;
    logic hi_srv;
    logic lo_srv;

    // bus decode: one wait cycle, then the edge that completes
    wire req_any = avs_read_in | avs_write_in;
    wire wr_take = avs_write_in & ack;
    wire lane0 = avs_byteenable_in[0];
    wire sel_main = avs_address_in == OFS_MAIN;
    wire sel_edges = avs_address_in == OFS_EDGES;
    wire sel_ext = avs_address_in == OFS_EXT;
    wire sel_rctl = avs_address_in == OFS_RESET_CTL;
    wire sel_stat = avs_address_in == OFS_STATUS;
    wire wr_main = wr_take & lane0 & sel_main;
    wire wr_edges = wr_take & lane0 & sel_edges;
    wire wr_ext = wr_take & lane0 & sel_ext;
    wire wr_rctl = wr_take & lane0 & sel_rctl;
    wire [7:0] wdata = avs_writedata_in[7:0];
    assign avs_waitrequest_out = req_any & ~ack;

    // read mux; unmapped addresses read zero
    wire [7:0] rd_edges = interrupt_control_edges_priority & MASK_EDGES;
    wire [7:0] rd_ext = interrupt_control_external_pins & MASK_EXT;
    wire [7:0] rd_rctl = {priority_mode_on, 7'h00};
    wire [7:0] rd_stat = {5'h00, state != ST_IDLE, lo_srv, hi_srv};
    wire [7:0] rd_mux = sel_main ? interrupt_control_main :
                        sel_edges ? rd_edges :
                        sel_ext ? rd_ext :
                        sel_rctl ? rd_rctl :
                        sel_stat ? rd_stat : 8'h00;

    // instruction tick from the core clock
    wire instr_tick = div_cnt == 2'(CLKS_PER_INSTR - 1);

    // external pin edges after synchronising
    wire [2:0] rise = ext_s2 & ~ext_d;
    wire [2:0] fall = ~ext_s2 & ext_d;
    wire [2:0] edge_sel = {interrupt_control_edges_priority[B_E2_EDGE],
                           interrupt_control_edges_priority[B_E1_EDGE],
                           interrupt_control_edges_priority[B_E0_EDGE]};
    wire [2:0] ext_evt = (edge_sel & rise) | (~edge_sel & fall);

    // mismatch against the value last read keeps setting the flag; mute while priming
    wire chg_evt = (chg_s2 != chg_ref) & (prime_cnt == 2'(PRIME_CYCLES));
    wire ref_load = port_read_in | (prime_cnt != 2'(PRIME_CYCLES));

    // per-source flag, enable and priority, order t0,e0,pc,e1,e2
    wire [4:0] src_flag = {interrupt_control_external_pins[B_E2_FLAG],
                           interrupt_control_external_pins[B_E1_FLAG],
                           interrupt_control_main[B_PC_FLAG],
                           interrupt_control_main[B_E0_FLAG],
                           interrupt_control_main[B_T0_FLAG]};
    wire [4:0] src_en = {interrupt_control_external_pins[B_E2_EN],
                         interrupt_control_external_pins[B_E1_EN],
                         interrupt_control_main[B_PC_EN],
                         interrupt_control_main[B_E0_EN],
                         interrupt_control_main[B_T0_EN]};
    // pin 0 has no priority bit and counts as high
    wire [4:0] src_prio = {interrupt_control_external_pins[B_E2_PRIO],
                           interrupt_control_external_pins[B_E1_PRIO],
                           interrupt_control_edges_priority[B_PC_PRIO],
                           1'b1,
                           interrupt_control_edges_priority[B_T0_PRIO]};
    wire [4:0] src_act = src_flag & src_en;

    // global gates
    wire en_hi = interrupt_control_main[B_HIGH_EN];
    wire en_lo = interrupt_control_main[B_LOW_EN];

    // compatibility: bit7 gates all, bit6 the peripherals too
    wire compat_req = en_hi & ((|src_act) | (en_lo & (|periph_req_in)));
    // priority mode: bit7 gates high; low also needs bit7 off-gate
    wire prio_hi = (|(src_act & src_prio)) | (|(periph_req_in & periph_prio_in));
    wire prio_lo = (|(src_act & ~src_prio)) | (|(periph_req_in & ~periph_prio_in));
    wire req_hi = priority_mode_on ? en_hi & prio_hi : compat_req;
    // low is gated by bit7 too, so it never breaks into a high routine
    wire req_lo = priority_mode_on & en_hi & en_lo & prio_lo;
    wire accept = (state == ST_IDLE) & instr_tick & (req_hi | req_lo);
    wire accept_hi = req_hi;
    // enable cleared on entry: high or single enable, else low
    wire clr_low = priority_mode_on & ~accept_hi;
    // return: innermost level first
    wire ret_low = priority_mode_on & ~hi_srv & lo_srv;

    // main register next value; hardware set wins over software clear
    always_comb begin
        next_main = interrupt_control_main;
        if (wr_main) begin
            next_main = wdata;
        end
        if (accept) begin
            next_main[clr_low ? B_LOW_EN : B_HIGH_EN] = 1'b0;
        end
        if (return_from_irq_instr_in) begin
            next_main[ret_low ? B_LOW_EN : B_HIGH_EN] = 1'b1;
        end
        // flags set whatever the enables say
        next_main[B_T0_FLAG] = next_main[B_T0_FLAG] | timer0_overflow_in;
        next_main[B_E0_FLAG] = next_main[B_E0_FLAG] | ext_evt[0];
        next_main[B_PC_FLAG] = next_main[B_PC_FLAG] | chg_evt;
    end

    // external pin register next value
    always_comb begin
        next_ext = interrupt_control_external_pins;
        if (wr_ext) begin
            next_ext = wdata & MASK_EXT;
        end
        next_ext[B_E1_FLAG] = next_ext[B_E1_FLAG] | ext_evt[1];
        next_ext[B_E2_FLAG] = next_ext[B_E2_FLAG] | ext_evt[2];
    end

    // vectoring steps advance one per instruction cycle
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (instr_tick) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (instr_tick) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // bus handshake and read data
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ack <= 1'b0;
            avs_readdata_out <= 32'h0000_0000;
        end else begin
            ack <= req_any & ~ack;
            // captured in the wait cycle, stands at the completing edge
            if (req_any & ~ack) begin
                avs_readdata_out <= {24'h00_0000, rd_mux};
            end
        end
    end

    // software-visible registers
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            interrupt_control_main <= RST_MAIN;
            interrupt_control_edges_priority <= RST_EDGES;
            interrupt_control_external_pins <= RST_EXT;
            priority_mode_on <= 1'b0;
        end else begin
            interrupt_control_main <= next_main;
            interrupt_control_external_pins <= next_ext;
            if (wr_edges) begin
                interrupt_control_edges_priority <= wdata & MASK_EDGES;
            end
            if (wr_rctl) begin
                priority_mode_on <= wdata[B_PRIO_MODE];
            end
        end
    end

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ext_s1 <= 3'h0;
            ext_s2 <= 3'h0;
            ext_d <= 3'h0;
            chg_s1 <= 4'h0;
            chg_s2 <= 4'h0;
        end else begin
            ext_s1 <= ext_pin_in;
            ext_s2 <= ext_s1;
            ext_d <= ext_s2;
            chg_s1 <= upper_four_port_pins_in;
            chg_s2 <= chg_s1;
        end
    end

    // port reference: primed after reset so idle pins raise nothing
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            chg_ref <= 4'h0;
            prime_cnt <= 2'h0;
        end else begin
            if (prime_cnt != 2'(PRIME_CYCLES)) begin
                prime_cnt <= prime_cnt + 2'h1;
            end
            if (ref_load) begin
                chg_ref <= chg_s2;
            end
        end
    end

    // instruction cycle divider
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= instr_tick ? 2'h0 : div_cnt + 2'h1;
        end
    end

    // vectoring sequence and in-service levels
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= ST_IDLE;
            take_high <= 1'b0;
            hi_srv <= 1'b0;
            lo_srv <= 1'b0;
        end else begin
            state <= next_state;
            if (accept) begin
                take_high <= accept_hi;
            end
            // level tracking lets the return re-open the right enable
            if (accept & accept_hi) begin
                hi_srv <= 1'b1;
            end else if (return_from_irq_instr_in & ~ret_low) begin
                hi_srv <= 1'b0;
            end
            if (accept & ~accept_hi) begin
                lo_srv <= 1'b1;
            end else if (return_from_irq_instr_in & ret_low) begin
                lo_srv <= 1'b0;
            end
        end
    end

    // core side: push then load, each a one-cycle pulse
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stack_push_out <= 1'b0;
            stack_data_out <= '0;
            pc_load_out <= 1'b0;
            pc_vector_out <= '0;
        end else begin
            stack_push_out <= (state == ST_PUSH) & instr_tick;
            pc_load_out <= (state == ST_LOAD) & instr_tick;
            if ((state == ST_PUSH) & instr_tick) begin
                stack_data_out <= return_addr_in;
            end
            if ((state == ST_LOAD) & instr_tick) begin
                // compatibility mode always takes the high vector
                pc_vector_out <= take_high ? VEC_HIGH : VEC_LOW;
            end
        end
    end

    // pull-ups follow the latches unless disabled
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pullup_en_out <= 8'h00;
        end else begin
            pullup_en_out <= interrupt_control_edges_priority[B_PULLUP_DIS] ?
                             8'h00 : port_latch_in;
        end
    end

    // checks
    property p_vec_lvl;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        pc_load_out |-> pc_vector_out == (take_high ? VEC_HIGH : VEC_LOW);
    endproperty
    a_vec_lvl: assert property (p_vec_lvl) else $error("wrong vector");

    property p_compat_vec;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        accept && !priority_mode_on |=> take_high;
    endproperty
    a_compat_vec: assert property (p_compat_vec) else $error("compat low");

    property p_clr_en;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        accept && !wr_main && !return_from_irq_instr_in |=>
            !interrupt_control_main[$past(clr_low) ? B_LOW_EN : B_HIGH_EN];
    endproperty
    a_clr_en: assert property (p_clr_en) else $error("enable kept");

    property p_push_load;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        stack_push_out |-> ##[1:4] pc_load_out;
    endproperty
    a_push_load: assert property (p_push_load) else $error("no load");

    property p_latency;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        accept |-> ##[5:9] pc_load_out;
    endproperty
    a_latency: assert property (p_latency) else $error("late vector");

    property p_flag_set;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        timer0_overflow_in |=> interrupt_control_main[B_T0_FLAG];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag lost");

    property p_no_lo_pre;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        hi_srv && priority_mode_on && !en_hi |-> !accept;
    endproperty
    a_no_lo_pre: assert property (p_no_lo_pre) else $error("low pre-empt");

    property p_ret_set;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        return_from_irq_instr_in && !priority_mode_on && !wr_main && !accept
            |=> interrupt_control_main[B_HIGH_EN];
    endproperty
    a_ret_set: assert property (p_ret_set) else $error("no re-enable");

    property p_pullup;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        interrupt_control_edges_priority[B_PULLUP_DIS] |=> pullup_en_out == 8'h00;
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up on");

    c_hi: cover property (@(posedge core_clk_in) accept && accept_hi);
    c_lo: cover property (@(posedge core_clk_in) accept && !accept_hi);
    c_pre: cover property (@(posedge core_clk_in) accept && accept_hi && lo_srv);
endmodule

// ==== dv/core_model.sv ====
`timescale 1ns/10ps
// behavioural core side: return stack plus a watch on the vector sequence
module core_model
    import irq_ctrl_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic arst_n_in,
    input wire logic stack_push_in,
    input wire logic [PC_W-1:0] stack_data_in,
    input wire logic pc_load_in,
    input wire logic [PC_W-1:0] pc_vector_in,
    input wire logic ret_req_in,
    output logic return_pulse_out,
    output logic [PC_W-1:0] last_vector_out,
    output logic [PC_W-1:0] top_of_stack_out,
    output logic [7:0] load_count_out,
    output logic order_err_out
);
    logic [PC_W-1:0] stack_mem [0:3]; // four nested levels, enough for two priorities
    logic [2:0] depth; // entries in use
    logic push_seen; // a push still waiting for its load
    wire logic [2:0] top_idx = depth - 3'h1; // newest entry
    assign top_of_stack_out = stack_mem[top_idx[1:0]];
    // push then load per accept; a return is issued when the bench asks
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            depth <= 3'h0;
            push_seen <= 1'b0;
            return_pulse_out <= 1'b0;
            last_vector_out <= '0;
            load_count_out <= 8'h00;
            order_err_out <= 1'b0;
        end else begin
            return_pulse_out <= ret_req_in;
            if (stack_push_in) begin
                stack_mem[depth[1:0]] <= stack_data_in;
                push_seen <= 1'b1;
                depth <= depth + 3'h1;
            end else if (ret_req_in && depth != 3'h0) begin
                depth <= depth - 3'h1;
            end
            // a load with no push before it is a broken sequence
            if (pc_load_in) begin
                order_err_out <= order_err_out | ~push_seen;
                push_seen <= 1'b0;
                last_vector_out <= pc_vector_in;
                load_count_out <= load_count_out + 8'h01;
            end
        end
    end
endmodule

// ==== dv/two_level_priority_interrupt_ctrl_bench.sv ====
`timescale 1ns/10ps
module two_level_priority_interrupt_ctrl_bench;
    import irq_ctrl_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [4:0] addr = 5'h00;
    logic rd_en = 1'b0, wr_en = 1'b0, t0 = 1'b0, prd = 1'b0, ret_req = 1'b0;
    logic [31:0] wdata = 32'h00000000, rdata, q;
    logic [3:0] be = 4'hF, pins = 4'h0, preq = 4'h0, pprio = 4'h0;
    logic [2:0] ext = 3'h0;
    logic [7:0] latch = 8'h00, pull, cnt;
    logic [PC_W-1:0] ret_addr = '0, sdata, vec, last_vec, top;
    logic waitreq, push, load, ret_p, oerr;
    int fails = 0, checks_done = 0, cyc = 0, lat;
    // clock, 4 ns period
    initial forever #2 clk = ~clk;
    two_level_priority_interrupt_ctrl #(.PERIPH_N(4)) dut (.core_clk_in(clk), .arst_n_in(arst_n),
        .avs_address_in(addr), .avs_read_in(rd_en), .avs_write_in(wr_en),
        .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .timer0_overflow_in(t0), .ext_pin_in(ext),
        .upper_four_port_pins_in(pins), .port_read_in(prd), .periph_req_in(preq),
        .periph_prio_in(pprio), .port_latch_in(latch), .pullup_en_out(pull),
        .return_addr_in(ret_addr), .return_from_irq_instr_in(ret_p), .stack_push_out(push),
        .stack_data_out(sdata), .pc_load_out(load), .pc_vector_out(vec));
    core_model core (.core_clk_in(clk), .arst_n_in(arst_n), .stack_push_in(push),
        .stack_data_in(sdata), .pc_load_in(load), .pc_vector_in(vec), .ret_req_in(ret_req),
        .return_pulse_out(ret_p), .last_vector_out(last_vec), .top_of_stack_out(top),
        .load_count_out(cnt), .order_err_out(oerr));
    // expected pull-up pattern
    function automatic logic [7:0] f_pull(input logic [7:0] edges, input logic [7:0] lt);
        return edges[B_PULLUP_DIS] ? 8'h00 : lt;
    endfunction
    // expected vector from mode and level
    function automatic logic [PC_W-1:0] f_vec(input logic prio_mode, input logic high);
        return (prio_mode && !high) ? VEC_LOW : VEC_HIGH;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask
    // one bus access; waitrequest sampled at each rising edge, request held until it is low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= {24'h000000, d};
        rd_en <= ~w;
        wr_en <= w;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 40);
        chk(n < 40, 32'h1);
        q = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h000000, e});
    endtask
    task automatic pulse_t0;
        @(posedge clk);
        t0 <= 1'b1;
        @(posedge clk);
        t0 <= 1'b0;
    endtask
    task automatic set_pins(input logic [2:0] v);
        @(posedge clk);
        ext <= v;
    endtask
    task automatic do_ret;
        @(posedge clk);
        ret_req <= 1'b1;
        @(posedge clk);
        ret_req <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // bounded wait for the next vector load, then vector and pushed address
    task automatic vec_chk(input logic [PC_W-1:0] e);
        logic [7:0] c0;
        c0 = cnt;
        lat = 0;
        while (cnt === c0 && lat < 60) begin
            @(negedge clk);
            lat++;
        end
        chk(lat < 60, 32'h1);
        chk({11'h000, last_vec}, {11'h000, e});
        chk({11'h000, top}, {11'h000, ret_addr});
    endtask
    // no vector may come within forty cycles, far beyond any latency
    task automatic no_vec;
        logic [7:0] c0;
        c0 = cnt;
        repeat (40) @(negedge clk);
        chk({24'h000000, cnt}, {24'h000000, c0});
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, the run needs some few hundred cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        int i;
        logic [7:0] v;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        void'($urandom(32'h7E33));
        repeat (4) @(posedge clk);
        // reset values, unimplemented bits, unmapped hole
        rdc(OFS_MAIN, RST_MAIN);
        rdc(OFS_EDGES, RST_EDGES);
        rdc(OFS_EXT, RST_EXT);
        rdc(OFS_STATUS, 8'h00);
        rdc(OFS_RESET_CTL, 8'h00);
        wr(OFS_EDGES, 8'hFF);
        rdc(OFS_EDGES, 8'hF5);
        wr(OFS_EXT, 8'hFC);
        rdc(OFS_EXT, 8'hD8);
        wr(5'h14, 8'hFF);
        rdc(5'h14, 8'h00);
        wr(OFS_EXT, 8'h00);
        $display("registers done");
        // pull-ups off or following random latches
        for (i = 0; i < 6; i++) begin
            v = 8'h75 | {i[0], 7'h00};
            @(posedge clk);
            latch <= 8'($urandom());
            wr(OFS_EDGES, v);
            repeat (3) @(negedge clk);
            chk({24'h000000, pull}, {24'h000000, f_pull(v, latch)});
        end
        $display("pull-ups done");
        // flags set with every enable off, rising then falling selects
        pulse_t0();
        set_pins(3'b111);
        repeat (10) @(posedge clk);
        rdc(OFS_MAIN, 8'h06);
        rdc(OFS_EXT, 8'h03);
        wr(OFS_MAIN, 8'h00);
        wr(OFS_EXT, 8'h00);
        wr(OFS_EDGES, 8'h05);
        set_pins(3'b000);
        repeat (10) @(posedge clk);
        rdc(OFS_MAIN, 8'h02);
        rdc(OFS_EXT, 8'h03);
        wr(OFS_MAIN, 8'h00);
        wr(OFS_EXT, 8'h00);
        set_pins(3'b111);
        repeat (10) @(posedge clk);
        rdc(OFS_MAIN, 8'h00);
        rdc(OFS_EXT, 8'h00);
        // port change flag sticks until the port is read
        @(posedge clk);
        pins <= 4'($urandom_range(1, 15));
        repeat (10) @(posedge clk);
        rdc(OFS_MAIN, 8'h01);
        wr(OFS_MAIN, 8'h00);
        rdc(OFS_MAIN, 8'h01);
        @(posedge clk);
        prd <= 1'b1;
        @(posedge clk);
        prd <= 1'b0;
        wr(OFS_MAIN, 8'h00);
        rdc(OFS_MAIN, 8'h00);
        $display("flags done");
        // compatibility mode, priority bits cleared yet one vector
        ret_addr <= 21'($urandom());
        wr(OFS_EDGES, 8'h70);
        wr(OFS_MAIN, 8'hA0);
        pulse_t0();
        vec_chk(f_vec(1'b0, 1'b0));
        rdc(OFS_MAIN, 8'h24);
        wr(OFS_MAIN, 8'h20);
        do_ret();
        rdc(OFS_MAIN, 8'hA0);
        @(posedge clk);
        preq <= 4'($urandom_range(1, 15));
        pprio <= 4'($urandom());
        no_vec();
        wr(OFS_MAIN, 8'hC0);
        vec_chk(VEC_HIGH);
        rdc(OFS_MAIN, 8'h40);
        no_vec();
        @(posedge clk);
        preq <= 4'h0;
        do_ret();
        rdc(OFS_MAIN, 8'hC0);
        $display("compatibility done");
        // priority mode: low taken, high pre-empts, low waits
        wr(OFS_RESET_CTL, 8'h80);
        rdc(OFS_RESET_CTL, 8'h80);
        set_pins(3'b000);
        wr(OFS_EXT, 8'h48);
        wr(OFS_MAIN, 8'hF0);
        pulse_t0();
        vec_chk(f_vec(1'b1, 1'b0));
        rdc(OFS_MAIN, 8'hB4);
        wr(OFS_MAIN, 8'hB0);
        set_pins(3'b001);
        vec_chk(f_vec(1'b1, 1'b1));
        // two extra: the model's count register and the half cycle before sampling
        chk(lat >= 3 * CLKS_PER_INSTR + 2 && lat <= 4 * CLKS_PER_INSTR + 2, 32'h1);
        rdc(OFS_MAIN, 8'hB2 & 8'h7F);
        rdc(OFS_STATUS, 8'h03);
        wr(OFS_MAIN, 8'h30);
        pulse_t0();
        no_vec();
        rdc(OFS_MAIN, 8'h34);
        wr(OFS_MAIN, 8'h30);
        do_ret();
        rdc(OFS_MAIN, 8'hB0);
        do_ret();
        rdc(OFS_MAIN, 8'hF0);
        // pin 1 high, pin 2 low
        set_pins(3'b011);
        vec_chk(VEC_HIGH);
        rdc(OFS_MAIN, 8'h70);
        wr(OFS_EXT, 8'h58);
        do_ret();
        set_pins(3'b111);
        vec_chk(VEC_LOW);
        rdc(OFS_MAIN, 8'hB0);
        wr(OFS_EXT, 8'h48);
        do_ret();
        // a cleared timer enable blocks its source; the flag still sets
        wr(OFS_MAIN, 8'hD0);
        pulse_t0();
        no_vec();
        rdc(OFS_MAIN, 8'hD4);
        chk({31'h0, oerr}, 32'h0);
        $display("priority mode done");
        close_out();
    end
endmodule
